//--- hw/rvq_qualifier.sv
// Receive video pass qualifier with truncation and transmit interrupts
`timescale 1ns/10ps
module rvq_qualifier (
    input  wire logic       clk,           // Core clock, 100 MHz
    input  wire logic       rst_n,         // Async reset, active low
    input  wire logic [7:0] reg_addr,      // Register offset
    input  wire logic [7:0] reg_wdata,     // Register write data
    input  wire logic       reg_we,        // Register write strobe
    input  wire logic       reg_re,        // Register read strobe
    output logic      [7:0] reg_rdata,     // Read data, next cycle
    output logic            irq,           // Transmit port interrupt
    output logic            pass,          // Pass indication
    input  wire logic       rx_lock,       // Receiver locked
    input  wire logic       rx_parity_err, // Link parity error pulse
    input  wire logic       rx_sync_ok,    // Input streams synchronized
    input  wire logic       rx_port_irq,   // Forwarded receive port event
    input  wire logic       in_valid,      // Video beat valid
    output logic            in_ready,      // Video beat accepted
    input  wire logic [7:0] in_data,       // Video byte
    input  wire logic       in_sof,        // Frame start marker beat
    input  wire logic       in_eol,        // Last byte of a line
    input  wire logic       in_eof,        // Frame end marker beat
    output logic            out_valid,     // Transmit beat valid
    input  wire logic       out_ready,     // Transmit port takes beat
    output logic      [7:0] out_data,      // Transmit byte
    output logic            out_sof,       // Transmit frame start
    output logic            out_eof        // Transmit frame end
);
    localparam int LW = rvq_pkg::RVQ_LEN_W;

    logic [7:0] irq_en_q;
    logic [7:0] trunc_cfg_q;
    logic [7:0] pass_ctl_q;
    logic [rvq_pkg::RVQ_IRQ_NUM-1:0] irq_st_q;
    logic [rvq_pkg::RVQ_IRQ_NUM-1:0] irq_ev;
    logic [2:0] rs_sticky_q;
    logic       pass_dly_q;
    logic       sync_dly_q;
    logic [1:0] vcount_q;
    logic [LW-1:0] len_cnt_q;
    logic [LW-1:0] ref_len_q;
    logic [LW-1:0] lines_q;
    logic [LW-1:0] ref_cnt_q;
    logic       ref_len_ok_q;
    logic       ref_cnt_ok_q;
    logic       frame_bad_q;
    rvq_pkg::rvq_state_t state_q;

    logic [1:0]    thresh;
    logic          qual_par;
    logic          qual_len;
    logic          qual_cnt;
    logic          discard_en;
    logic          acc;
    logic          is_sof;
    logic          is_eof;
    logic          is_dat;
    logic          eol_hit;
    logic [LW-1:0] cur_len;
    logic          len_chg;
    logic          cnt_chg;
    logic          par_hit;
    logic          restart;
    logic          frame_ok;
    logic          pass_d;
    logic          allow;
    logic          trunc_now;
    logic          wr;
    logic [rvq_pkg::RVQ_FIFO_W-1:0] fifo_out;

    assign thresh     = pass_ctl_q[rvq_pkg::RVQ_THRESH_MSB:
                                   rvq_pkg::RVQ_THRESH_LSB];
    assign qual_par   = pass_ctl_q[rvq_pkg::RVQ_QUAL_PAR_BIT];
    assign qual_len   = pass_ctl_q[rvq_pkg::RVQ_QUAL_LEN_BIT];
    assign qual_cnt   = pass_ctl_q[rvq_pkg::RVQ_QUAL_CNT_BIT];
    assign discard_en = pass_ctl_q[rvq_pkg::RVQ_DISCARD_BIT];

    // Beat classification; a marker beat carries no payload
    assign acc     = in_valid & in_ready;
    assign is_sof  = acc & in_sof;
    assign is_eof  = acc & in_eof & ~in_sof;
    assign is_dat  = acc & ~in_sof & ~in_eof;
    assign eol_hit = is_dat & in_eol;
    assign cur_len = len_cnt_q + LW'(1);

    assign len_chg = eol_hit & ref_len_ok_q & (cur_len != ref_len_q);
    assign cnt_chg = is_eof & ref_cnt_ok_q & (lines_q != ref_cnt_q);
    assign par_hit = rx_parity_err & qual_par;

    assign restart = (len_chg & qual_len) | (cnt_chg & qual_cnt)
                   | par_hit | ~rx_lock;

    // parity alone never spoils the frame it lands in
    assign frame_ok = is_eof & ~frame_bad_q & ~(cnt_chg & qual_cnt);

    // pass decision against the two-bit threshold
    always_comb
    begin
        pass_d = pass;
        if (!rx_lock)
            pass_d = 1'b0;
        else if (par_hit)
            pass_d = 1'b0;
        else if (thresh == 2'h0)
            pass_d = 1'b1;
        else if (restart)
            pass_d = 1'b0;
        else if (frame_ok && ({1'b0, vcount_q} + 3'h1 >= {1'b0, thresh}))
            pass_d = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pass <= 1'b0;
        else
            pass <= pass_d;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            vcount_q <= 2'h0;
        else if (restart)
            vcount_q <= 2'h0;
        else if (frame_ok && vcount_q != rvq_pkg::RVQ_VCNT_MAX)
            vcount_q <= vcount_q + 2'h1;
    end

    // Line length and line count measurement
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            len_cnt_q    <= '0;
            ref_len_q    <= '0;
            lines_q      <= '0;
            ref_cnt_q    <= '0;
            ref_len_ok_q <= 1'b0;
            ref_cnt_ok_q <= 1'b0;
            frame_bad_q  <= 1'b0;
        end
        else if (!rx_lock)
        begin
            // Old references mean nothing after relock
            ref_len_ok_q <= 1'b0;
            ref_cnt_ok_q <= 1'b0;
            frame_bad_q  <= 1'b1;
        end
        else
        begin
            if (is_sof)
            begin
                len_cnt_q   <= '0;
                lines_q     <= '0;
                frame_bad_q <= 1'b0;
            end
            else if (eol_hit)
            begin
                len_cnt_q    <= '0;
                lines_q      <= lines_q + LW'(1);
                ref_len_q    <= cur_len;
                ref_len_ok_q <= 1'b1;
                if (len_chg && qual_len)
                    frame_bad_q <= 1'b1;
            end
            else if (is_dat)
                len_cnt_q <= cur_len;
            else if (is_eof)
            begin
                ref_cnt_q    <= lines_q;
                ref_cnt_ok_q <= 1'b1;
            end
        end
    end

    // an error ends the frame being sent
    assign allow     = ~discard_en | pass;
    assign trunc_now =
        (trunc_cfg_q[rvq_pkg::RVQ_TRUNC_SIZE_BIT] & (len_chg | cnt_chg))
        | (trunc_cfg_q[rvq_pkg::RVQ_TRUNC_PAR_BIT] & rx_parity_err)
        | ~allow;

    // nothing is written while discarding before pass
    always_comb
    begin
        wr = 1'b0;
        case (state_q)
            rvq_pkg::RVQ_IDLE:
                wr = is_sof & allow;
            rvq_pkg::RVQ_FWD:
                wr = (is_sof & allow) | (~trunc_now & (is_dat | is_eof));
            rvq_pkg::RVQ_DROP:
                wr = is_sof & allow & ~rx_parity_err;
            default:
                wr = 1'b0;
        endcase
    end

    // only a frame start leaves idle; drop also leaves on a frame end
    // truncation goes to drop without a frame end
    // may happen after any number of lines
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= rvq_pkg::RVQ_IDLE;
        else
        begin
            case (state_q)
                rvq_pkg::RVQ_IDLE:
                    if (is_sof && allow)
                        state_q <= rvq_pkg::RVQ_FWD;
                rvq_pkg::RVQ_FWD:
                    if (is_sof && allow)
                        state_q <= rvq_pkg::RVQ_FWD;
                    else if (trunc_now)
                        state_q <= rvq_pkg::RVQ_DROP;
                    else if (is_eof)
                        state_q <= rvq_pkg::RVQ_IDLE;
                rvq_pkg::RVQ_DROP:
                    if (is_sof && allow && !rx_parity_err)
                        state_q <= rvq_pkg::RVQ_FWD;
                    else if (is_eof)
                        state_q <= rvq_pkg::RVQ_IDLE;
                default:
                    state_q <= rvq_pkg::RVQ_IDLE;
            endcase
        end
    end

    // Stalling the FIFO stalls the link side through in_ready
    rvq_fifo #(
        .WIDTH (rvq_pkg::RVQ_FIFO_W),
        .DEPTH (rvq_pkg::RVQ_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (wr),
        .in_ready  (in_ready),
        .in_data   ({is_sof, is_eof, in_data}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (fifo_out)
    );
    assign out_sof  = fifo_out[rvq_pkg::RVQ_FIFO_W-1];
    assign out_eof  = fifo_out[rvq_pkg::RVQ_FIFO_W-2];
    assign out_data = fifo_out[rvq_pkg::RVQ_DATA_W-1:0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pass_dly_q <= 1'b0;
            sync_dly_q <= 1'b0;
        end
        else
        begin
            pass_dly_q <= pass;
            sync_dly_q <= rx_sync_ok;
        end
    end

    always_comb
    begin
        irq_ev = '0;
        irq_ev[rvq_pkg::RVQ_IRQ_PASS_BIT]      = pass & ~pass_dly_q;
        irq_ev[rvq_pkg::RVQ_IRQ_SYNC_BIT]      = rx_sync_ok & ~sync_dly_q;
        irq_ev[rvq_pkg::RVQ_IRQ_PASS_LOST_BIT] = ~pass & pass_dly_q;
        irq_ev[rvq_pkg::RVQ_IRQ_SYNC_LOST_BIT] = ~rx_sync_ok & sync_dly_q;
        irq_ev[rvq_pkg::RVQ_IRQ_RX_FWD_BIT]    = rx_port_irq;
    end

    // status ignores enables; set beats clear on read
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_st_q <= '0;
        else if (reg_re && reg_addr == rvq_pkg::RVQ_IRQ_ST_OFS)
            irq_st_q <= irq_ev;
        else
            irq_st_q <= irq_st_q | irq_ev;
    end

    // Sticky receive flags, clear on read, set wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rs_sticky_q <= 3'h0;
        else if (reg_re && reg_addr == rvq_pkg::RVQ_RX_STATUS_OFS)
            rs_sticky_q <= {rx_parity_err, cnt_chg, len_chg};
        else
            rs_sticky_q <= rs_sticky_q | {rx_parity_err, cnt_chg, len_chg};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(irq_st_q & irq_en_q[rvq_pkg::RVQ_IRQ_NUM-1:0]);
    end

    // Control register writes
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_en_q    <= rvq_pkg::RVQ_IRQ_EN_RST;
            trunc_cfg_q <= rvq_pkg::RVQ_TRUNC_CFG_RST;
            pass_ctl_q  <= rvq_pkg::RVQ_PASS_CTL_RST;
        end
        else if (reg_we)
        begin
            case (reg_addr)
                rvq_pkg::RVQ_IRQ_EN_OFS:    irq_en_q    <= reg_wdata;
                rvq_pkg::RVQ_TRUNC_CFG_OFS: trunc_cfg_q <= reg_wdata;
                rvq_pkg::RVQ_PASS_CTL_OFS:  pass_ctl_q  <= reg_wdata;
                default:                    ;
            endcase
        end
    end

    // Register reads; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_re)
        begin
            case (reg_addr)
                rvq_pkg::RVQ_IRQ_EN_OFS:    reg_rdata <= irq_en_q;
                rvq_pkg::RVQ_IRQ_ST_OFS:
                    reg_rdata <= {3'h0, irq_st_q};
                rvq_pkg::RVQ_TRUNC_CFG_OFS: reg_rdata <= trunc_cfg_q;
                rvq_pkg::RVQ_PASS_CTL_OFS:  reg_rdata <= pass_ctl_q;
                rvq_pkg::RVQ_RX_STATUS_OFS:
                    reg_rdata <= {3'h0, rs_sticky_q, rx_lock, pass};
                default:                    reg_rdata <= 8'h00;
            endcase
        end
    end

    pass_par_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        par_hit |=> !pass)
        else $error("pass held after qualified parity error");

    cnt_par_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        par_hit |=> vcount_q == 2'h0)
        else $error("counter kept after parity error");

    lock_loss_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rx_lock |=> !pass && vcount_q == 2'h0)
        else $error("pass or counter kept without lock");

    thresh_zero_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        rx_lock && !par_hit && thresh == 2'h0 |=> pass)
        else $error("pass not raised on lock at zero threshold");

    count_step_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        frame_ok && !restart && vcount_q == 2'h1 |=> vcount_q == 2'h2)
        else $error("valid frame not counted");

    len_restart_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        len_chg && qual_len |=> vcount_q == 2'h0 && rs_sticky_q[0])
        else $error("line size change not restarting or flagged");

    status_set_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        pass && !$past(pass) && irq_en_q == 8'h00
        |=> irq_st_q[rvq_pkg::RVQ_IRQ_PASS_BIT])
        else $error("pass status not set while disabled");

    drop_no_fe_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        state_q == rvq_pkg::RVQ_DROP && is_eof |-> !wr)
        else $error("frame end sent for truncated frame");

    discard_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        discard_en && !pass |-> !wr)
        else $error("video written while discarding");

    sof_first_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr && state_q != rvq_pkg::RVQ_FWD |-> is_sof)
        else $error("output resumed without frame start");
endmodule : rvq_qualifier

//--- hw/rvq_pkg.sv
// Constants and types shared by the receive video pass qualifier
package rvq_pkg;
    // Register offsets
    localparam logic [7:0] RVQ_IRQ_EN_OFS    = 8'h36;
    localparam logic [7:0] RVQ_IRQ_ST_OFS    = 8'h37;
    localparam logic [7:0] RVQ_TRUNC_CFG_OFS = 8'h7C;
    localparam logic [7:0] RVQ_PASS_CTL_OFS  = 8'h7D;
    localparam logic [7:0] RVQ_RX_STATUS_OFS = 8'h7E;

    // Reset values
    localparam logic [7:0] RVQ_IRQ_EN_RST    = 8'h00;
    localparam logic [7:0] RVQ_TRUNC_CFG_RST = 8'h00;
    localparam logic [7:0] RVQ_PASS_CTL_RST  = 8'h00;

    // Interrupt status and enable bit positions
    localparam int RVQ_IRQ_PASS_BIT      = 0;
    localparam int RVQ_IRQ_SYNC_BIT      = 1;
    localparam int RVQ_IRQ_PASS_LOST_BIT = 2;
    localparam int RVQ_IRQ_SYNC_LOST_BIT = 3;
    localparam int RVQ_IRQ_RX_FWD_BIT    = 4;
    localparam int RVQ_IRQ_NUM           = 5;

    // Truncation configuration bits
    localparam int RVQ_TRUNC_SIZE_BIT = 0;
    localparam int RVQ_TRUNC_PAR_BIT  = 1;

    // Pass control fields
    localparam int RVQ_THRESH_LSB    = 0;
    localparam int RVQ_THRESH_MSB    = 1;
    localparam int RVQ_QUAL_PAR_BIT  = 2;
    localparam int RVQ_QUAL_LEN_BIT  = 3;
    localparam int RVQ_QUAL_CNT_BIT  = 4;
    localparam int RVQ_DISCARD_BIT   = 7;

    // Receive status bits
    localparam int RVQ_RS_PASS_BIT    = 0;
    localparam int RVQ_RS_LOCK_BIT    = 1;
    localparam int RVQ_RS_LEN_CHG_BIT = 2;
    localparam int RVQ_RS_CNT_CHG_BIT = 3;
    localparam int RVQ_RS_PAR_BIT     = 4;

    // Widths and depths
    localparam int RVQ_DATA_W     = 8;
    localparam int RVQ_LEN_W      = 16;
    localparam int RVQ_FIFO_W     = RVQ_DATA_W + 2;
    localparam int RVQ_FIFO_DEPTH = 8;
    localparam logic [1:0] RVQ_VCNT_MAX = 2'h3;

    typedef enum logic [1:0] {
        RVQ_IDLE,
        RVQ_FWD,
        RVQ_DROP
    } rvq_state_t;
endpackage : rvq_pkg

//--- hw/rvq_fifo.sv
// Synchronous FIFO between the qualifier and the transmit port
`timescale 1ns/10ps
module rvq_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,       // Core clock
    input  wire logic             rst_n,     // Async reset, active low
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Not full
    input  wire logic [WIDTH-1:0] in_data,   // Write word
    output logic                  out_valid, // Not empty
    input  wire logic             out_ready, // Reader takes word
    output logic      [WIDTH-1:0] out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW:0] ONE_C   = (AW+1)'(1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    always_comb
    begin
        count_d = count_q;
        if (push & ~pop)
            count_d = count_q + ONE_C;
        else if (pop & ~push)
            count_d = count_q - ONE_C;
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
            count_q   <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0
                                                          : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0
                                                          : rd_ptr_q + 1'b1;
            count_q   <= count_d;
            in_ready  <= (count_d != DEPTH_C);
            out_valid <= (count_d != '0);
        end
    end
endmodule : rvq_fifo

//--- testbench/rvq_ser_model.sv
// Behavioural remote serializer that streams video frames
`timescale 1ns/10ps
module rvq_ser_model (
    input  wire logic       clk,      // Core clock
    input  wire logic       in_ready, // Qualifier accepts beat
    output logic            in_valid, // Beat valid
    output logic      [7:0] in_data,  // Video byte
    output logic            in_sof,   // Frame start beat
    output logic            in_eol,   // Last byte of a line
    output logic            in_eof    // Frame end beat
);
    initial
    begin
        in_valid = 1'b0;
        in_data  = 8'h5A;
        in_sof   = 1'b0;
        in_eol   = 1'b0;
        in_eof   = 1'b0;
    end

    // Everything holds until the edge that samples in_ready high
    task automatic beat(input logic s, input logic e, input logic f,
                        input logic [7:0] d);
        in_valid <= 1'b1;
        in_sof   <= s;
        in_eol   <= e;
        in_eof   <= f;
        in_data  <= d;
        @(posedge clk);
        while (in_ready !== 1'b1)
            @(posedge clk);
    endtask : beat

    // Bytes count up from 1 so the receiver can sum them
    task automatic send_frame(input int lines, input int len);
        logic [7:0] k;
        k = 8'h00;
        @(posedge clk);
        beat(1'b1, 1'b0, 1'b0, ~in_data);
        for (int l = 0; l < lines; l++)
            for (int i = 0; i < len; i++)
            begin
                k = k + 8'h01;
                beat(1'b0, i == len - 1, 1'b0, k);
            end
        beat(1'b0, 1'b0, 1'b1, ~k);
        // A released data line must not keep showing the last byte
        in_valid <= 1'b0;
        in_eof   <= 1'b0;
        in_eol   <= 1'b0;
        in_data  <= ~in_data;
    endtask : send_frame
endmodule : rvq_ser_model

//--- testbench/rvq_qualifier_tb.sv
// Self-checking bench for the receive video pass qualifier
`timescale 1ns/10ps
module rvq_qualifier_tb;
    logic       clk;
    logic       rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_we;
    logic       reg_re;
    logic [7:0] reg_rdata;
    logic       irq;
    logic       pass;
    logic       rx_lock;
    logic       rx_parity_err;
    logic       rx_sync_ok;
    logic       rx_port_irq;
    logic       in_valid;
    logic       in_ready;
    logic [7:0] in_data;
    logic       in_sof;
    logic       in_eol;
    logic       in_eof;
    logic       out_valid;
    logic       out_ready;
    logic [7:0] out_data;
    logic       out_sof;
    logic       out_eof;
    logic [7:0] sof_n;
    logic [7:0] eof_n;
    logic [7:0] dat_n;
    logic [7:0] dsum;
    logic [7:0] e0;
    int         err_total;
    int         checked;
    int         cyc;

    rvq_qualifier u_rvq_qualifier (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq), .pass(pass),
        .rx_lock(rx_lock), .rx_parity_err(rx_parity_err),
        .rx_sync_ok(rx_sync_ok), .rx_port_irq(rx_port_irq),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .in_sof(in_sof), .in_eol(in_eol), .in_eof(in_eof),
        .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_sof(out_sof), .out_eof(out_eof));

    rvq_ser_model u_rvq_ser_model (.clk(clk), .in_ready(in_ready),
        .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
        .in_eol(in_eol), .in_eof(in_eof));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Tally of transmit beats taken by the consumer
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1 && out_ready)
        begin
            sof_n <= sof_n + {7'h0, out_sof};
            eof_n <= eof_n + {7'h0, out_eof};
            if (!out_sof && !out_eof)
            begin
                dat_n <= dat_n + 8'h01;
                dsum  <= dsum + out_data;
            end
        end
        if (cyc == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask : wr

    // Sampled a full cycle late: the data holds until the next read
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge clk);
        reg_re   <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("reg_rdata", reg_rdata, exp);
    endtask : rd

    task automatic gap(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : gap

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        {reg_addr, reg_wdata, reg_we, reg_re} = '0;
        {rx_lock, rx_parity_err, rx_sync_ok, rx_port_irq} = '0;
        {sof_n, eof_n, dat_n, dsum, e0} = '0;
        out_ready = 1'b1;
        rst_n = 1'b0;
        err_total = 0;
        checked = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rd(8'h36, 8'h00);
        rd(8'h7C, 8'h00);
        rd(8'h7D, 8'h00);
        wr(8'h55, 8'hFF);
        rd(8'h55, 8'h00);
        wr(8'h7C, 8'h03);
        rd(8'h7C, 8'h03);
        wr(8'h7C, 8'h00);
        @(posedge clk);
        rx_lock <= 1'b1;
        gap(3);
        chk("pass", {7'h0, pass}, 8'h01);
        rd(8'h37, 8'h01);
        chk("irq", {7'h0, irq}, 8'h00);
        wr(8'h36, 8'h1F);
        @(posedge clk);
        rx_sync_ok  <= 1'b1;
        rx_port_irq <= 1'b1;
        @(posedge clk);
        rx_port_irq <= 1'b0;
        gap(3);
        chk("irq", {7'h0, irq}, 8'h01);
        rd(8'h37, 8'h12);
        gap(3);
        chk("irq", {7'h0, irq}, 8'h00);
        @(posedge clk);
        rx_lock    <= 1'b0;
        rx_sync_ok <= 1'b0;
        gap(3);
        chk("pass", {7'h0, pass}, 8'h00);
        rd(8'h37, 8'h0C);
        wr(8'h36, 8'h00);
        wr(8'h7D, 8'h9A);
        @(posedge clk);
        rx_lock <= 1'b1;
        gap(3);
        chk("pass", {7'h0, pass}, 8'h00);
        u_rvq_ser_model.send_frame(2, 3);
        gap(3);
        chk("pass", {7'h0, pass}, 8'h00);
        chk("sof_n", sof_n, 8'h00);
        u_rvq_ser_model.send_frame(2, 3);
        gap(3);
        chk("pass", {7'h0, pass}, 8'h01);
        @(posedge clk);
        out_ready <= 1'b0;
        u_rvq_ser_model.send_frame(2, 3);
        gap(2);
        chk("in_ready", {7'h0, in_ready}, 8'h00);
        @(posedge clk);
        out_ready <= 1'b1;
        gap(12);
        chk("sof_n", sof_n, 8'h01);
        chk("eof_n", eof_n, 8'h01);
        chk("dat_n", dat_n, 8'h06);
        chk("dsum", dsum, 8'h15);
        // Threshold two keeps one clean frame after a parity hit
        wr(8'h7D, 8'h9E);
        fork
            u_rvq_ser_model.send_frame(2, 3);
            begin
                repeat (3) @(posedge clk);
                rx_parity_err <= 1'b1;
                @(posedge clk);
                rx_parity_err <= 1'b0;
                gap(1);
                chk("pass", {7'h0, pass}, 8'h00);
            end
        join
        gap(3);
        chk("pass", {7'h0, pass}, 8'h00);
        u_rvq_ser_model.send_frame(2, 3);
        gap(3);
        chk("pass", {7'h0, pass}, 8'h01);
        wr(8'h7C, 8'h01);
        e0 = eof_n;
        u_rvq_ser_model.send_frame(2, 4);
        gap(12);
        chk("eof_n", eof_n, e0);
        chk("pass", {7'h0, pass}, 8'h00);
        rd(8'h7E, 8'h16);
        // One extra line per frame must restart counting and be flagged
        u_rvq_ser_model.send_frame(3, 4);
        gap(3);
        chk("pass", {7'h0, pass}, 8'h00);
        rd(8'h7E, 8'h0A);
        u_rvq_ser_model.send_frame(3, 4);
        gap(3);
        chk("pass", {7'h0, pass}, 8'h00);
        tally_and_finish();
    end
endmodule : rvq_qualifier_tb
